// ==== srov_trip_top.v ====
// Start-up residual overvoltage trip: APB registers and decision logic
`timescale 1ns/100ps
`include "srov_defines.vh"
module srov_trip_top #(
    parameter W = 16,
    parameter TICK_CYC = `SROV_TICK_CYC
) (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Residual voltage samples
    input wire signed [W-1:0] sample,
    input wire sample_valid,
    input wire period_end,
    // User logic
    input wire block_input,
    // Outputs
    output reg general_start_out,
    output reg general_trip_out,
    output reg event_pulse
);
    ////////////////////////////////////////////////////////////////////////////////
    reg operation_enable;
    reg start_only;
    reg [6:0] pickup_threshold_pct;
    reg [15:0] definite_delay_ms;
    reg [15:0] rated_level;
    reg [3:0] event_flags;
    wire [W-1:0] rms_equiv;
    wire rms_valid;
    wire char_start_flag;
    wire char_trip_flag;
    wire [22:0] pickup_prod;
    wire [22:0] pickup_quot;
    wire [W-1:0] pickup_level;
    wire next_start;
    wire next_trip;
    wire [3:0] ev_set;
    wire wr;
    wire rd;
    reg [31:0] next_rdata;
    reg next_err;

    function [6:0] clamp_pct;
        input [31:0] v;
        begin
            if (v[31:0] < {25'd0, `SROV_THRESH_MIN})
                clamp_pct = `SROV_THRESH_MIN;
            else if (v[31:0] > {25'd0, `SROV_THRESH_MAX})
                clamp_pct = `SROV_THRESH_MAX;
            else
                clamp_pct = v[6:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Threshold as level: rated * pct / 100
    assign pickup_prod = rated_level * pickup_threshold_pct;
    assign pickup_quot = pickup_prod / 23'd100;
    assign pickup_level = pickup_quot[W-1:0];

    srov_pp_meas #(
        .W(W),
        .WIN(W)
    ) u_meas (
        .pclk(pclk),
        .presetn(presetn),
        .sample(sample),
        .sample_valid(sample_valid),
        .period_end(period_end),
        .rms_equiv(rms_equiv),
        .rms_valid(rms_valid)
    );

    srov_char #(
        .W(W),
        .TICK_CYC(TICK_CYC)
    ) u_char (
        .pclk(pclk),
        .presetn(presetn),
        .rms_equiv(rms_equiv),
        .rms_valid(rms_valid),
        .pickup_level(pickup_level),
        .delay_ms(definite_delay_ms),
        .char_start_flag(char_start_flag),
        .char_trip_flag(char_trip_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decision logic
    assign next_start = operation_enable && !block_input && char_start_flag;
    // No latch: trip follows the flag directly
    assign next_trip = operation_enable && !block_input && !start_only && char_trip_flag;

    assign ev_set[`SROV_EV_START_ON] = next_start && !general_start_out;
    assign ev_set[`SROV_EV_START_OFF] = !next_start && general_start_out;
    assign ev_set[`SROV_EV_TRIP_ON] = next_trip && !general_trip_out;
    assign ev_set[`SROV_EV_TRIP_OFF] = !next_trip && general_trip_out;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_start_out <= 1'b0;
            general_trip_out <= 1'b0;
            event_pulse <= 1'b0;
        end else begin
            general_start_out <= next_start;
            general_trip_out <= next_trip;
            event_pulse <= |ev_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB registers
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `SROV_REG_CTRL: next_rdata = {30'd0, start_only, operation_enable};
            `SROV_REG_THRESH: next_rdata = {25'd0, pickup_threshold_pct};
            `SROV_REG_DELAY: next_rdata = {16'd0, definite_delay_ms};
            `SROV_REG_STATUS: next_rdata = {28'd0, char_trip_flag, char_start_flag,
                                            general_trip_out, general_start_out};
            `SROV_REG_EVENT: next_rdata = {28'd0, event_flags};
            `SROV_REG_RATED: next_rdata = {16'd0, rated_level};
            `SROV_REG_MEAS: next_rdata = {{(32-W){1'b0}}, rms_equiv};
            default: next_err = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operation_enable <= 1'b0;
            start_only <= 1'b0;
            pickup_threshold_pct <= `SROV_THRESH_RST;
            definite_delay_ms <= `SROV_DELAY_RST;
            rated_level <= `SROV_RATED_RST;
            event_flags <= 4'h0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            if (rd)
                prdata <= next_rdata;
            if (wr && paddr == `SROV_REG_CTRL) begin
                operation_enable <= pwdata[`SROV_CTRL_OPER];
                start_only <= pwdata[`SROV_CTRL_STONLY];
            end
            if (wr && paddr == `SROV_REG_THRESH)
                pickup_threshold_pct <= clamp_pct(pwdata);
            if (wr && paddr == `SROV_REG_DELAY)
                definite_delay_ms <= (pwdata[31:0] > {16'd0, `SROV_DELAY_MAX}) ?
                    `SROV_DELAY_MAX : pwdata[15:0];
            if (wr && paddr == `SROV_REG_RATED)
                rated_level <= pwdata[15:0];
            // Write one to clear; a new event in the same cycle wins
            if (wr && paddr == `SROV_REG_EVENT)
                event_flags <= (event_flags & ~pwdata[3:0]) | ev_set;
            else
                event_flags <= event_flags | ev_set;
        end
    end
endmodule // srov_trip_top

// ==== srov_defines.vh ====
// Constants and register map of the start-up residual overvoltage trip block
`ifndef SROV_DEFINES_VH
`define SROV_DEFINES_VH

// Register byte addresses
`define SROV_REG_CTRL 12'h000
`define SROV_REG_THRESH 12'h004
`define SROV_REG_DELAY 12'h008
`define SROV_REG_STATUS 12'h00c
`define SROV_REG_EVENT 12'h010
`define SROV_REG_RATED 12'h014
`define SROV_REG_MEAS 12'h018

// Control fields
`define SROV_CTRL_OPER 0
`define SROV_CTRL_STONLY 1

// Status and event fields
`define SROV_ST_GSTART 0
`define SROV_ST_GTRIP 1
`define SROV_ST_CSTART 2
`define SROV_ST_CTRIP 3
`define SROV_EV_START_ON 0
`define SROV_EV_START_OFF 1
`define SROV_EV_TRIP_ON 2
`define SROV_EV_TRIP_OFF 3

// Reset values and limits
`define SROV_THRESH_MIN 7'd2
`define SROV_THRESH_MAX 7'd60
`define SROV_THRESH_RST 7'd30
`define SROV_DELAY_MAX 16'd60000
`define SROV_DELAY_RST 16'd200
`define SROV_RATED_RST 16'h4000

// Timing: 10 MHz clock, 1 ms tick
`define SROV_CLK_HZ 10000000
`define SROV_TICK_US 1000
`define SROV_TICK_CYC (`SROV_CLK_HZ / 1000000 * `SROV_TICK_US)

// Peak-to-peak to RMS scale: 1/(2*sqrt(2)) as 0.16 fraction
`define SROV_PP2RMS 16'h5a82

`endif

// ==== srov_pp_meas.v ====
// Peak-to-peak residual voltage measurement with RMS scaling
`timescale 1ns/100ps
`include "srov_defines.vh"
module srov_pp_meas #(
    parameter W = 16,
    parameter WIN = 16
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Sample stream of the fourth voltage channel
    input wire signed [W-1:0] sample,
    input wire sample_valid,
    input wire period_end,
    // Scaled result
    output reg [W-1:0] rms_equiv,
    output reg rms_valid
);
    reg signed [W-1:0] vmax;
    reg signed [W-1:0] vmin;
    reg [W-1:0] held_pp;
    reg pp_ready;
    reg first;
    wire [W:0] pp_wide;
    wire [W+15:0] prod;

    // Window spans one signal period, so the figure follows 7 to 35 Hz alike
    assign pp_wide = {vmax[W-1], vmax} - {vmin[W-1], vmin};
    assign prod = held_pp * `SROV_PP2RMS;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vmax <= {W{1'b0}};
            vmin <= {W{1'b0}};
            held_pp <= {W{1'b0}};
            pp_ready <= 1'b0;
            first <= 1'b1;
            rms_equiv <= {W{1'b0}};
            rms_valid <= 1'b0;
        end else begin
            // Valid trails the held value by one cycle, so it meets the scaled result
            rms_valid <= pp_ready;
            pp_ready <= 1'b0;
            rms_equiv <= prod[W+15:16];
            if (sample_valid) begin
                if (first || period_end) begin
                    vmax <= sample;
                    vmin <= sample;
                    first <= 1'b0;
                end else begin
                    if (sample > vmax)
                        vmax <= sample;
                    if (sample < vmin)
                        vmin <= sample;
                end
                if (period_end && !first) begin
                    // Saturate: an input swinging beyond full scale reads full scale
                    held_pp <= pp_wide[W] ? {W{1'b1}} : pp_wide[W-1:0];
                    pp_ready <= 1'b1;
                end
            end
        end
    end
endmodule // srov_pp_meas

// ==== srov_char.v ====
// Definite-time characteristic: start flag and delayed trip flag
`timescale 1ns/100ps
`include "srov_defines.vh"
module srov_char #(
    parameter W = 16,
    parameter TICK_CYC = `SROV_TICK_CYC
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Measurement
    input wire [W-1:0] rms_equiv,
    input wire rms_valid,
    input wire [W-1:0] pickup_level,
    input wire [15:0] delay_ms,
    // Flags
    output reg char_start_flag,
    output reg char_trip_flag
);
    reg [15:0] ms_count;
    reg [23:0] tick_count;
    wire above;
    wire tick;

    assign above = rms_equiv > pickup_level;
    assign tick = (tick_count == TICK_CYC - 1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            char_start_flag <= 1'b0;
            char_trip_flag <= 1'b0;
            ms_count <= 16'h0000;
            tick_count <= 24'h000000;
        end else if (rms_valid && !above) begin
            // Drop out on the first period below pickup
            char_start_flag <= 1'b0;
            char_trip_flag <= 1'b0;
            ms_count <= 16'h0000;
            tick_count <= 24'h000000;
        end else if (char_start_flag || (rms_valid && above)) begin
            char_start_flag <= 1'b1;
            // Timer starts at the first period measured above pickup, so the
            // measuring time adds to the delay rather than counting within it
            if (ms_count >= delay_ms)
                char_trip_flag <= 1'b1;
            if (tick) begin
                tick_count <= 24'h000000;
                if (ms_count != 16'hffff)
                    ms_count <= ms_count + 16'h0001;
            end else begin
                tick_count <= tick_count + 24'h000001;
            end
        end
    end
endmodule // srov_char

// ==== srov_trip_checker.sv ====
// Assertion checker for the start-up residual overvoltage trip block
`timescale 1ns/100ps
`include "srov_defines.vh"
module srov_trip_checker (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Bus and user inputs
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire block_input,
    // Outputs
    input wire general_start_out,
    input wire general_trip_out,
    input wire event_pulse
);
    // Shadow of the control word, taken at the access edge
    reg [1:0] ctl;
    wire gs = general_start_out;
    wire gt = general_trip_out;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 2'h0;
        end else if (psel && penable && pwrite && pready && paddr == `SROV_REG_CTRL) begin
            ctl <= pwdata[1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence blk_held;
        block_input [*3];
    endsequence
    a_off_quiet: assert property ((!ctl[0]) [*3] |=> !gs && !gt) else $error("out while off");
    a_stonly_notrip: assert property (ctl[1] [*3] |=> !gt) else $error("trip in start-only");
    a_trip_with_start: assert property (gt |-> gs) else $error("trip without start");
    a_block_start: assert property (blk_held |=> !gs) else $error("start while blocked");
    a_block_trip: assert property (blk_held |=> !gt) else $error("trip while blocked");
    a_event_change: assert property ($changed(gs) || $changed(gt) |-> event_pulse)
        else $error("change without event");
    a_event_cause: assert property (event_pulse |-> $changed(gs) || $changed(gt))
        else $error("event without change");
    a_trip_drops: assert property ($fell(gs) |-> !gt) else $error("trip held");
endmodule // srov_trip_checker
bind srov_trip_top srov_trip_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .block_input, .general_start_out, .general_trip_out, .event_pulse);

// ==== srov_relay_model.sv ====
// Model of the user logic and trip stage beside the block
`timescale 1ns/100ps
module srov_relay_model (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Command and block output
    input wire block_cmd,
    input wire general_trip_out,
    // Towards the block, and the trip counter
    output reg block_input,
    output reg [7:0] trip_count
);
    reg trip_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_input <= 1'b0;
            trip_q <= 1'b0;
            trip_count <= 8'h00;
        end else begin
            block_input <= block_cmd;
            trip_q <= general_trip_out;
            if (general_trip_out && !trip_q) begin
                trip_count <= trip_count + 8'h01;
            end
        end
    end
endmodule // srov_relay_model

// ==== startup_residual_overvoltage_trip_test.sv ====
// Self-checking bench of the start-up residual overvoltage trip block
`timescale 1ns/100ps
`include "srov_defines.vh"
module startup_residual_overvoltage_trip_test;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg signed [15:0] sample = 16'sh0;
    reg sample_valid = 1'b0;
    reg period_end = 1'b0;
    reg blk_cmd = 1'b0;
    reg [15:0] amp = 16'd1000;
    reg [4:0] ph = 5'h0;
    reg [31:0] rd;
    reg err;
    reg [61:0] rows [0:11];
    wire [31:0] prdata;
    wire pready, pslverr, gs, gt, ev, blk;
    wire [7:0] trips;
    integer miscompares = 0;
    integer num_checks = 0;
    integer n, i;
    srov_trip_top #(.TICK_CYC(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample(sample), .sample_valid(sample_valid),
        .period_end(period_end), .block_input(blk), .general_start_out(gs),
        .general_trip_out(gt), .event_pulse(ev));
    srov_relay_model i_relay (.pclk(pclk), .presetn(presetn), .block_cmd(blk_cmd),
        .general_trip_out(gt), .block_input(blk), .trip_count(trips));
    always #50 pclk = ~pclk;
    // Square wave, 8 samples a period of 32 cycles
    always @(posedge pclk) begin
        ph <= ph + 5'h1;
        sample_valid <= (ph[1:0] == 2'h3);
        period_end <= (ph == 5'h1f);
        sample <= ph[4] ? -$signed(amp) : $signed(amp);
    end
    task summarize;
        begin
            $display("checks %0d miscompares %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Waits for general start (t=0) or trip (t=1) to reach v, counting cycles
    task wt(input t, input v);
        begin
            n = 0;
            while (((t ? gt : gs) !== v) && n < 400) begin
                @(posedge pclk);
                n = n + 1;
            end
        end
    endtask
    // Aligns a new amplitude to a period start, so the fault time is known
    task inj(input [15:0] v);
        begin
            @(posedge pclk);
            while (ph !== 5'h1f) @(posedge pclk);
            amp <= v;
        end
    endtask
    initial begin
        #4000000;
        miscompares = miscompares + 1;
        summarize;
    end
    initial begin
        rows[0] = {1'b0, `SROV_REG_CTRL, 32'h0, 16'd0, 1'b0};
        rows[1] = {1'b0, `SROV_REG_THRESH, 32'h0, 16'd30, 1'b0};
        rows[2] = {1'b0, `SROV_REG_DELAY, 32'h0, 16'd200, 1'b0};
        rows[3] = {1'b0, 12'h020, 32'h0, 16'd0, 1'b1};
        rows[4] = {1'b1, `SROV_REG_THRESH, 32'd1, 16'd0, 1'b0};
        rows[5] = {1'b0, `SROV_REG_THRESH, 32'h0, 16'd2, 1'b0};
        rows[6] = {1'b1, `SROV_REG_THRESH, 32'd61, 16'd0, 1'b0};
        rows[7] = {1'b0, `SROV_REG_THRESH, 32'h0, 16'd60, 1'b0};
        rows[8] = {1'b1, `SROV_REG_DELAY, 32'd70000, 16'd0, 1'b0};
        rows[9] = {1'b0, `SROV_REG_DELAY, 32'h0, 16'd60000, 1'b0};
        rows[10] = {1'b0, `SROV_REG_RATED, 32'h0, `SROV_RATED_RST, 1'b0};
        rows[11] = {1'b0, `SROV_REG_STATUS, 32'h0, 16'h0, 1'b0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            apb(rows[i][61], rows[i][60:49], rows[i][48:17]);
            if (!rows[i][61]) chk(rd, {16'h0, rows[i][16:1]});
            chk({31'h0, err}, {31'h0, rows[i][0]});
        end
        apb(1'b1, `SROV_REG_THRESH, 32'd30);
        apb(1'b1, `SROV_REG_DELAY, 32'd8);
        inj(16'd12000);
        repeat (150) @(posedge pclk);
        chk({30'h0, gs, gt}, 32'h0);
        inj(16'd1000);
        // Let the flags settle first, so enabling raises no stale trip
        repeat (40) @(posedge pclk);
        apb(1'b1, `SROV_REG_CTRL, 32'h1);
        // Short fault, dropped before the delay ends
        inj(16'd12000);
        wt(0, 1);
        chk({31'h0, gs}, 32'h1);
        inj(16'd1000);
        wt(0, 0);
        chk({31'h0, gt}, 32'h0);
        inj(16'd12000);
        wt(1, 1);
        chk({31'h0, n >= 80 && n <= 150}, 32'h1);
        blk_cmd <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({30'h0, gs, gt}, 32'h0);
        blk_cmd <= 1'b0;
        wt(1, 1);
        chk({31'h0, n < 8}, 32'h1);
        inj(16'd1000);
        wt(0, 0);
        chk({31'h0, n <= 128}, 32'h1);
        chk({31'h0, gt}, 32'h0);
        apb(1'b1, `SROV_REG_DELAY, 32'd0);
        inj(16'd12000);
        wt(1, 1);
        chk({31'h0, n <= 112}, 32'h1);
        apb(1'b1, `SROV_REG_CTRL, 32'h3);
        repeat (8) @(posedge pclk);
        chk({30'h0, gs, gt}, 32'h2);
        apb(1'b1, `SROV_REG_CTRL, 32'h0);
        repeat (8) @(posedge pclk);
        chk({30'h0, gs, gt}, 32'h0);
        chk({24'h0, trips}, 32'd3);
        apb(1'b0, `SROV_REG_EVENT, 32'h0);
        chk(rd, 32'hf);
        apb(1'b1, `SROV_REG_EVENT, 32'hf);
        apb(1'b0, `SROV_REG_EVENT, 32'h0);
        chk(rd, 32'h0);
        summarize;
    end
endmodule // startup_residual_overvoltage_trip_test
